// [host_model.sv]
// behavioural two-wire bus master that drives the block's serial pins
// assumes a pull-up on sda; it reads high unless someone pulls it low
`timescale 1ns/10ps
`default_nettype none
module host_model (
  input  wire logic mclk,
  input  wire logic sda,
  output var  logic scl,
  output var  logic sda_pull
);
  logic r;
  initial begin
    scl = 1'h1;
    sda_pull = 1'h0;
  end
  task automatic w(input int n);
    repeat (n) @(negedge mclk);
  endtask
  // also a repeated start: the data line is released before scl rises
  task automatic start_c();
    sda_pull = 1'h0;
    w(8);
    scl = 1'h1;
    w(8);
    sda_pull = 1'h1;
    w(8);
    scl = 1'h0;
  endtask
  task automatic stop_c();
    w(8);
    sda_pull = 1'h1;
    w(8);
    scl = 1'h1;
    w(8);
    sda_pull = 1'h0;
    w(16);
  endtask
  // data changes halfway through the low phase, after the target lets go of sda
  task automatic bit_c(input logic b, output logic got);
    w(8);
    sda_pull = ~b;
    w(8);
    scl = 1'h1;
    w(4);
    got = sda;
    w(4);
    scl = 1'h0;
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_c(b[i], r);
    bit_c(1'h1, r);
    ack = ~r;
  endtask
  task automatic recv(input logic last, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_c(1'h1, d[i]);
    bit_c(last, r);
  endtask
endmodule
`default_nettype wire

// [light_cmd_defs.svh]
// constants for the command decoder and the function enable register
// assumes inclusion by the design module and the bench alike
`ifndef LIGHT_CMD_DEFS_SVH
`define LIGHT_CMD_DEFS_SVH

`define CMD_SELECT_BIT    7
`define KIND_HI           6
`define KIND_LO           5
`define KIND_REPEAT       2'h0
`define KIND_INCR         2'h1
`define KIND_SPECIAL      2'h3
`define SF_PROX_CLR       5'h05
`define SF_CLEAR_CLR      5'h06
`define SF_BOTH_CLR       5'h07
`define FUNC_ENABLE_ADDR  5'h00
`define FUNC_ENABLE_RESET 6'h00
`define EN_PROX_IRQ       5
`define EN_CLEAR_IRQ      4
`define EN_WAIT           3
`define EN_PROX_FUNC      2
`define EN_COLOR          1
`define EN_OSC_PON        0
`define DEV_ADDR_DEFAULT  7'h2A

`endif

// [light_cmd_pkg.sv]
// types shared by the command decoder modules
// assumes light_cmd_defs.svh is on the include path
package light_cmd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_WR_BYTE, ST_ACK_WR, ST_RD_BYTE,
    ST_RD_ACK
  } bus_state_t;
  typedef logic [4:0] reg_addr_t;
endpackage

// [light_cmd_regs.sv]
// two-wire bus target with command byte decoder and function enable register
// assumes scl/sda pins arrive asynchronously; other registers sit outside
`timescale 1ns/10ps
`default_nettype none
`include "light_cmd_defs.svh"

// Function
// - kind 00 keeps the same register for every following data byte
// - kind 01 advances the register address after each data byte
// - bits 4:0 are an address for normal kinds, a function code for 11
// - codes 00101, 00110, 00111 clear prox, clear-channel, both interrupts
// - an interrupt clear drops its pending bits once and needs no undo
// - proximity interrupts arise only while enable bit 5 is one
// - clear-channel interrupts arise only while enable bit 4 is one
// - enable bit 3 turns the wait timer on and off
// - enable bit 2 turns the proximity function on and off
// - enable bit 1 starts and stops the color conversions
// - enable bit 0 starts and stops the internal oscillator
// - the oscillator runs during any bus access regardless of bit 0
// - a data write without a command goes to the last selected address
// - a read without a new command uses the previously selected address
module light_cmd_regs
  import light_cmd_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = `DEV_ADDR_DEFAULT  // arbitrary value
) (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output var  logic       sda_out,
  output var  logic       sda_oe,
  input  wire logic       prox_irq_event,
  input  wire logic       clear_irq_event,
  input  wire logic [7:0] reg_rdata,
  output var  logic [4:0] reg_addr,
  output var  logic [7:0] reg_wdata,
  output var  logic       reg_wr,
  output var  logic       reg_rd,
  output var  logic       prox_irq_pending,
  output var  logic       clear_irq_pending,
  output var  logic       prox_irq_enable,
  output var  logic       clear_irq_enable,
  output var  logic       wait_enable,
  output var  logic       prox_function_enable,
  output var  logic       color_measure_enable,
  output var  logic       oscillator_run
);
  logic [1:0] pins_s;
  logic       scl_s, sda_s, scl_p, sda_p;
  logic       rise, fall, start_c, stop_c;
  bus_state_t state_q;
  logic [2:0] cnt_q;
  logic [7:0] shift_q, tx_q, byte_in, rd_value;
  logic       got8_q, match_q, rw_q, first_q, nack_q, busy_q, oe_q;
  reg_addr_t  addr_q;
  logic [1:0] kind_q;
  logic [5:0] en_q;
  logic       wr_take, cmd_take, data_take, rd_done, en_write;
  logic       sf_prox, sf_clear, advance;

  pin_sync #(.WIDTH(2)) u_sync (
    .mclk     (mclk),
    .reset    (reset),
    .async_in ({scl_in, sda_in}),
    .sync_out (pins_s)
  );
  assign scl_s = pins_s[1];
  assign sda_s = pins_s[0];

  always_ff @(posedge mclk) begin
    if (reset) begin
      scl_p <= 1'b1;
      sda_p <= 1'b1;
    end else begin
      scl_p <= scl_s;
      sda_p <= sda_s;
    end
  end

  assign rise    = scl_s & ~scl_p;
  assign fall    = ~scl_s & scl_p;
  assign start_c = scl_s & scl_p & sda_p & ~sda_s;
  assign stop_c  = scl_s & scl_p & ~sda_p & sda_s;
  assign byte_in = {shift_q[6:0], sda_s};

  // byte events, decoded on the rising edge of the eighth bit, or of the acknowledge bit after a read byte
  assign wr_take   = (state_q == ST_WR_BYTE) && rise && (cnt_q == 3'h7);
  assign cmd_take  = wr_take && first_q && byte_in[`CMD_SELECT_BIT];
  assign data_take = wr_take && !cmd_take;
  assign rd_done   = (state_q == ST_RD_ACK) && rise;
  assign en_write  = data_take && (addr_q == `FUNC_ENABLE_ADDR);
  assign sf_prox   = cmd_take &&
                     (byte_in[`KIND_HI:`KIND_LO] == `KIND_SPECIAL) &&
                     ((byte_in[4:0] == `SF_PROX_CLR) ||
                      (byte_in[4:0] == `SF_BOTH_CLR));
  assign sf_clear  = cmd_take &&
                     (byte_in[`KIND_HI:`KIND_LO] == `KIND_SPECIAL) &&
                     ((byte_in[4:0] == `SF_CLEAR_CLR) ||
                      (byte_in[4:0] == `SF_BOTH_CLR));
  // kind 10 is reserved and simply holds the address like kind 00
  assign advance   = (data_take || rd_done) && (kind_q == `KIND_INCR);
  // reserved enable bits read back as zero
  assign rd_value  = (addr_q == `FUNC_ENABLE_ADDR) ? {2'h0, en_q}
                                                   : reg_rdata;

  // serial bus sequencing; start and stop win over any bit activity
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      cnt_q   <= 3'h0;
      shift_q <= 8'h00;
      tx_q    <= 8'h00;
      got8_q  <= 1'b0;
      match_q <= 1'b0;
      rw_q    <= 1'b0;
      first_q <= 1'b0;
      nack_q  <= 1'b0;
      oe_q    <= 1'b0;
    end else if (start_c) begin
      state_q <= ST_ADDR;
      cnt_q   <= 3'h0;
      got8_q  <= 1'b0;
      oe_q    <= 1'b0;
    end else if (stop_c) begin
      state_q <= ST_IDLE;
      oe_q    <= 1'b0;
    end else begin
      case (state_q)
        ST_ADDR, ST_WR_BYTE: begin
          if (rise && !got8_q) begin
            shift_q <= byte_in;
            cnt_q   <= cnt_q + 3'h1;
            if (cnt_q == 3'h7) begin
              got8_q <= 1'b1;
              if (state_q == ST_ADDR) begin
                match_q <= (shift_q[6:0] == DEV_ADDR);
                rw_q    <= sda_s;
              end else begin
                first_q <= 1'b0;
              end
            end
          end else if (fall && got8_q) begin
            got8_q <= 1'b0;
            if (state_q == ST_WR_BYTE) begin
              state_q <= ST_ACK_WR;
              oe_q    <= 1'b1;
            end else if (match_q) begin
              state_q <= ST_ACK_ADDR;
              oe_q    <= 1'b1;
              first_q <= 1'b1;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_ACK_ADDR, ST_ACK_WR: begin
          if (fall) begin
            cnt_q <= 3'h0;
            if (state_q == ST_ACK_ADDR && rw_q) begin
              state_q <= ST_RD_BYTE;
              tx_q    <= rd_value;
              oe_q    <= ~rd_value[7];
            end else begin
              state_q <= ST_WR_BYTE;
              oe_q    <= 1'b0;
            end
          end
        end
        ST_RD_BYTE: begin
          if (fall) begin
            cnt_q <= cnt_q + 3'h1;
            tx_q  <= {tx_q[6:0], 1'b0};
            if (cnt_q == 3'h7) begin
              state_q <= ST_RD_ACK;
              oe_q    <= 1'b0;
            end else begin
              oe_q <= ~tx_q[6];
            end
          end
        end
        ST_RD_ACK: begin
          if (rise) begin
            nack_q <= sda_s;
          end else if (fall) begin
            cnt_q <= 3'h0;
            if (nack_q) begin
              state_q <= ST_IDLE;
            end else begin
              state_q <= ST_RD_BYTE;
              tx_q    <= rd_value;
              oe_q    <= ~rd_value[7];
            end
          end
        end
        default: begin
          state_q <= state_q;
        end
      endcase
    end
  end

  // transaction activity, from start to stop
  always_ff @(posedge mclk) begin
    if (reset) begin
      busy_q <= 1'b0;
    end else if (start_c) begin
      busy_q <= 1'b1;
    end else if (stop_c) begin
      busy_q <= 1'b0;
    end
  end

  // register pointer and access kind survive between transactions
  always_ff @(posedge mclk) begin
    if (reset) begin
      addr_q <= `FUNC_ENABLE_ADDR;
      kind_q <= `KIND_REPEAT;
    end else if (cmd_take &&
                 byte_in[`KIND_HI:`KIND_LO] != `KIND_SPECIAL) begin
      addr_q <= byte_in[4:0];
      kind_q <= byte_in[`KIND_HI:`KIND_LO];
    end else if (advance) begin
      addr_q <= addr_q + 5'h01;
    end
  end

  // only bits 5:0 hold state; bits 7:6 are expected as zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      en_q <= `FUNC_ENABLE_RESET;
    end else if (en_write) begin
      en_q <= byte_in[5:0];
    end
  end

  // a new event in the clearing cycle survives the clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      prox_irq_pending  <= 1'b0;
      clear_irq_pending <= 1'b0;
    end else begin
      prox_irq_pending  <= (prox_irq_event & en_q[`EN_PROX_IRQ]) |
                           (prox_irq_pending & ~sf_prox);
      clear_irq_pending <= (clear_irq_event & en_q[`EN_CLEAR_IRQ]) |
                           (clear_irq_pending & ~sf_clear);
    end
  end

  // outward strobes to the registers held outside this block
  always_ff @(posedge mclk) begin
    if (reset) begin
      reg_wr    <= 1'b0;
      reg_rd    <= 1'b0;
      reg_wdata <= 8'h00;
    end else begin
      reg_wr    <= data_take && (addr_q != `FUNC_ENABLE_ADDR);
      reg_rd    <= fall && rw_q &&
                   ((state_q == ST_ACK_ADDR) ||
                    (state_q == ST_RD_ACK && !nack_q));
      if (data_take) begin
        reg_wdata <= byte_in;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sda_out              <= 1'b0;
      sda_oe               <= 1'b0;
      reg_addr             <= `FUNC_ENABLE_ADDR;
      prox_irq_enable      <= 1'b0;
      clear_irq_enable     <= 1'b0;
      wait_enable          <= 1'b0;
      prox_function_enable <= 1'b0;
      color_measure_enable <= 1'b0;
      oscillator_run       <= 1'b0;
    end else begin
      sda_out              <= 1'b0;
      sda_oe               <= oe_q;
      reg_addr             <= addr_q;
      prox_irq_enable      <= en_q[`EN_PROX_IRQ];
      clear_irq_enable     <= en_q[`EN_CLEAR_IRQ];
      wait_enable          <= en_q[`EN_WAIT];
      prox_function_enable <= en_q[`EN_PROX_FUNC];
      color_measure_enable <= en_q[`EN_COLOR];
      oscillator_run       <= en_q[`EN_OSC_PON] | busy_q;
    end
  end

  sequence s_kind_write;
    data_take && (kind_q == `KIND_REPEAT);
  endsequence
  sequence s_cmd_select;
    cmd_take && (byte_in[`KIND_HI:`KIND_LO] != `KIND_SPECIAL);
  endsequence

  repeat_addr_a: assert property (@(posedge mclk) disable iff (reset)
    s_kind_write |=> $stable(addr_q) ##1 (reg_addr == $past(addr_q, 2)))
    else $error("repeat kind moved the address");
  incr_addr_a: assert property (@(posedge mclk) disable iff (reset)
    (data_take && kind_q == `KIND_INCR) |=>
      (addr_q == $past(addr_q) + 5'h01))
    else $error("auto increment did not advance");
  cmd_addr_a: assert property (@(posedge mclk) disable iff (reset)
    s_cmd_select |=> (addr_q == $past(byte_in[4:0])) ##1
      (reg_addr == $past(addr_q)))
    else $error("command address not taken");
  sf_keep_a: assert property (@(posedge mclk) disable iff (reset)
    (cmd_take && byte_in[`KIND_HI:`KIND_LO] == `KIND_SPECIAL) |=>
      $stable(addr_q) && $stable(kind_q))
    else $error("special function changed the pointer");
  prox_clear_a: assert property (@(posedge mclk) disable iff (reset)
    (cmd_take && byte_in == 8'hE5 && !prox_irq_event) |=>
      !prox_irq_pending)
    else $error("proximity clear failed");
  both_clear_a: assert property (@(posedge mclk) disable iff (reset)
    (cmd_take && byte_in == 8'hE7 && !prox_irq_event &&
     !clear_irq_event) |=> !prox_irq_pending && !clear_irq_pending)
    else $error("combined clear left a bit set");
  prox_gate_a: assert property (@(posedge mclk) disable iff (reset)
    (!en_q[`EN_PROX_IRQ] && !prox_irq_pending) |=> !prox_irq_pending)
    else $error("proximity interrupt while disabled");
  clear_gate_a: assert property (@(posedge mclk) disable iff (reset)
    (!en_q[`EN_CLEAR_IRQ] && !clear_irq_pending) |=> !clear_irq_pending)
    else $error("clear interrupt while disabled");
  enable_write_a: assert property (@(posedge mclk) disable iff (reset)
    en_write |=> ##1 (prox_function_enable == $past(byte_in[2], 2)) &&
      (wait_enable == $past(byte_in[3], 2)) &&
      (color_measure_enable == $past(byte_in[1], 2)))
    else $error("enable fields not applied");
  osc_busy_a: assert property (@(posedge mclk) disable iff (reset)
    (busy_q || en_q[`EN_OSC_PON]) |=> oscillator_run)
    else $error("oscillator stopped during access");
  read_src_a: assert property (@(posedge mclk) disable iff (reset)
    (state_q == ST_ACK_ADDR && fall && rw_q && !start_c && !stop_c) |=>
      (tx_q == $past(rd_value)) && reg_rd && (reg_addr == addr_q))
    else $error("read did not use held address");
endmodule
`default_nettype wire

// [pin_sync.sv]
// two-flop synchroniser, one stage pair per bit
// assumes asynchronous inputs, all reads taken from the second stage
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 2
) (
  input  wire logic             mclk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      always_ff @(posedge mclk) begin
        if (reset) begin
          meta_q      <= 1'b1;
          sync_out[i] <= 1'b1;
        end else begin
          meta_q      <= async_in[i];
          sync_out[i] <= meta_q;
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the command decoder and function enable register
// assumes host_model as bus master and a far register file of {3'h5, addr}
`timescale 1ns/10ps
`default_nettype none
`include "light_cmd_defs.svh"
module tb;
  import light_cmd_pkg::*;
  logic        mclk, reset, prox_ev, clear_ev, ack;
  logic        scl, sda_pull, sda_out, sda_oe, reg_wr, reg_rd;
  logic        prox_irq_pending, clear_irq_pending, oscillator_run;
  logic        prox_irq_enable, clear_irq_enable, wait_enable;
  logic        prox_function_enable, color_measure_enable;
  reg_addr_t   reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, en_now;
  logic [12:0] wq [$];
  int          n_mismatch, num_checks, n_rd;
  wire logic   sda;
  logic [7:0]  pats [3] = '{8'h2A, 8'h00, 8'h15};
  logic [7:0]  codes [3] = '{8'hE5, 8'hE6, 8'hE7};
  logic [12:0] wexp [6] = '{13'h03A1, 13'h03A2, 13'h0322, 13'h04B1,
                           13'h05B2, 13'h06B3};
  assign sda = ~(sda_pull | (sda_oe & ~sda_out));
  assign reg_rdata = {3'h5, reg_addr};
  assign en_now = {2'h0, prox_irq_enable, clear_irq_enable, wait_enable,
                   prox_function_enable, color_measure_enable,
                   oscillator_run};
  light_cmd_regs light_cmd_regs_inst (
    .mclk(mclk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .prox_irq_event(prox_ev),
    .clear_irq_event(clear_ev), .reg_rdata(reg_rdata),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .prox_irq_pending(prox_irq_pending),
    .clear_irq_pending(clear_irq_pending),
    .prox_irq_enable(prox_irq_enable), .clear_irq_enable(clear_irq_enable),
    .wait_enable(wait_enable), .prox_function_enable(prox_function_enable),
    .color_measure_enable(color_measure_enable),
    .oscillator_run(oscillator_run)
  );
  host_model host_model_inst (
    .mclk(mclk), .sda(sda), .scl(scl), .sda_pull(sda_pull)
  );
  initial mclk = 1'h0;
  always #20 mclk = ~mclk;
  // strobes are looked at mid-cycle, away from the edge that launches them
  always @(negedge mclk) begin
    if (reg_wr === 1'h1) wq.push_back({reg_addr, reg_wdata});
    if (reg_rd === 1'h1) n_rd++;
  end
  task automatic complete_run();
    if (n_mismatch == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] b [4], input int n);
    logic ok;
    host_model_inst.start_c();
    host_model_inst.send({`DEV_ADDR_DEFAULT, 1'h0}, ok);
    for (int i = 0; i < n; i++) begin
      host_model_inst.send(b[i], ack);
      ok &= ack;
    end
    host_model_inst.stop_c();
    chk(ok, 1'h1);
  endtask
  task automatic rd(input logic cmd, input logic [7:0] c, e0, e1);
    logic [7:0] d0, d1;
    if (cmd) begin
      host_model_inst.start_c();
      host_model_inst.send({`DEV_ADDR_DEFAULT, 1'h0}, ack);
      host_model_inst.send(c, ack);
    end
    host_model_inst.start_c();
    host_model_inst.send({`DEV_ADDR_DEFAULT, 1'h1}, ack);
    host_model_inst.recv(1'h0, d0);
    host_model_inst.recv(1'h1, d1);
    host_model_inst.stop_c();
    chk(d0, e0);
    chk(d1, e1);
  endtask
  // both events for one cycle apart from any clear command
  task automatic pulse();
    @(negedge mclk);
    prox_ev = 1'h1;
    clear_ev = 1'h1;
    @(negedge mclk);
    prox_ev = 1'h0;
    clear_ev = 1'h0;
    repeat (4) @(negedge mclk);
  endtask
  initial begin
    repeat (40000) @(posedge mclk);
    n_mismatch++;
    complete_run();
  end
  initial begin
    reset = 1'h1;
    prox_ev = 1'h0;
    clear_ev = 1'h0;
    repeat (3) @(negedge mclk);
    reset = 1'h0;
    repeat (6) @(negedge mclk);
    chk(en_now, 8'h00);
    chk({prox_irq_pending, clear_irq_pending}, 2'h0);
    // a foreign address must not be acknowledged
    host_model_inst.start_c();
    host_model_inst.send({`DEV_ADDR_DEFAULT ^ 7'h01, 1'h0}, ack);
    chk(ack, 1'h0);
    host_model_inst.stop_c();
    host_model_inst.start_c();
    host_model_inst.send({`DEV_ADDR_DEFAULT, 1'h0}, ack);
    chk(oscillator_run, 1'h1);
    host_model_inst.stop_c();
    chk(oscillator_run, 1'h0);
    foreach (pats[i]) begin
      wr('{8'h80, pats[i], 8'h00, 8'h00}, 2);
      chk(en_now, pats[i]);
    end
    rd(1'h1, 8'h80, 8'h15, 8'h15);
    wq.delete();
    wr('{8'h83, 8'hA1, 8'hA2, 8'h00}, 3);
    wr('{8'h22, 8'h00, 8'h00, 8'h00}, 1);
    wr('{8'hA4, 8'hB1, 8'hB2, 8'hB3}, 4);
    chk(16'(wq.size()), 16'h0006);
    foreach (wexp[i]) chk(wq[i], wexp[i]);
    wr('{8'h83, 8'h00, 8'h00, 8'h00}, 1);
    rd(1'h0, 8'h00, 8'hA3, 8'hA3);
    rd(1'h1, 8'hA8, 8'hA8, 8'hA9);
    // enable is still 0x15 here: clear-channel allowed, proximity not
    pulse();
    chk({prox_irq_pending, clear_irq_pending}, 2'h1);
    wr('{8'h80, 8'h31, 8'h00, 8'h00}, 2);
    foreach (codes[i]) begin
      pulse();
      chk({prox_irq_pending, clear_irq_pending}, 2'h3);
      wr('{codes[i], 8'h00, 8'h00, 8'h00}, 1);
      repeat (40) @(negedge mclk);
      chk({prox_irq_pending, clear_irq_pending},
          {codes[i][1:0] == 2'h2, codes[i][1:0] == 2'h1});
    end
    // three reads of two bytes each, the last one not acknowledged, fetch six times
    chk(16'(n_rd), 16'h0006);
    complete_run();
  end
endmodule
`default_nettype wire
